/* File: verilog/urfcam_top.sv */
// Receive side of an async serial port: framing check, address filter.
// Assumes AXI4-Lite master, rx line idle high, single core clock.
// Notes on behaviour
// - Framing check in modes 1-3, select-bit enabled
// - Invalid stop bit sets framing error flag
// - Framing flag sticky until software or reset
// - Check enabled: done flag at stop bit
// - Address filter active when multiproc bit set
// - Done flag only on own address match
// - Mode 1 filter: stop bit acts as ninth
// - Multiproc bit ignored in shift mode
// - Given address: mask selects compared bits
// - Broadcast is address OR mask
// - Either given or broadcast hit matches
// - Address and mask reset to zero
// - Receiver runs independent of transmit side
// - Control bit 7: error flag or mode bit
// - Mode 1 unfiltered: ninth flag takes stop
//
// Decided for this implementation: register access over AXI4-Lite.
module urfcam_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              rx_i,
  output logic                   irq_o
);
  // ==========================================================
  // Elaboration check: index needs address bits 9:2
  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W must be at least 10");
  end

  // Word index of a byte address
  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  // Known register index
  function automatic logic mapped(input logic [7:0] i);
    return (i == urfcam_pkg::IDX_SERIAL_CTRL) ||
           (i == urfcam_pkg::IDX_NODE_ADDR) ||
           (i == urfcam_pkg::IDX_NODE_MASK) ||
           (i == urfcam_pkg::IDX_POWER_CTRL) ||
           (i == urfcam_pkg::IDX_RX_DATA) ||
           (i == urfcam_pkg::IDX_BAUD_DIV) ||
           (i == urfcam_pkg::IDX_IRQ_STATUS) ||
           (i == urfcam_pkg::IDX_IRQ_MASK);
  endfunction

  // ==========================================================
  // Register state
  logic [7:0]  node_address;       // Own address
  logic [7:0]  node_address_mask;  // Own address mask
  logic        serial_mode_bit0;   // Mode bit 0
  logic        serial_mode_bit1;   // Mode bit 1
  logic        multiproc_enable;   // Multiprocessor filter on
  logic        rx_enable;          // Reception enable
  logic        tx_ninth_bit;       // Stored for the transmit side
  logic        received_ninth_bit; // Ninth bit or stop bit
  logic        tx_done_flag;       // Stored for the transmit side
  logic        receive_done_flag;  // Frame taken
  logic        framing_error_flag; // Sticky framing error
  logic        frame_check_select; // Framing check enable
  logic [7:0]  rx_data;            // Last accepted byte
  logic [15:0] baud_div;           // Cycles per bit minus one
  logic [1:0]  irq_status;         // Sticky event bits
  logic [1:0]  irq_mask;           // Event enables

  // ==========================================================
  // Bus slave state
  logic [7:0]  aw_idx;  // Latched write index
  logic [31:0] w_data;  // Latched write data
  logic [3:0]  w_strb;  // Latched byte enables
  logic        wr_fire; // Both halves held, perform write
  logic        wr_map;  // Write index is mapped
  logic [31:0] rd_val;  // Read mux result

  assign wr_fire = !s_axi_awready_o && !s_axi_wready_o &&
                   !s_axi_bvalid_o;
  assign wr_map  = mapped(aw_idx);

  // Lane 0 write to an index
  function automatic logic wr_lo(input logic [7:0] i);
    return wr_fire && (aw_idx == i) && w_strb[0];
  endfunction

  // Write address channel; released again after response
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      aw_idx          <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_axi_awready_o <= 1'b0;
      aw_idx          <= idx_of(s_axi_awaddr_i);
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  // Write data channel, taken in either order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_wready_o <= 1'b1;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_axi_wready_o <= 1'b0;
      w_data         <= s_axi_wdata_i;
      w_strb         <= s_axi_wstrb_i;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  // Write response; unmapped index answers with an error
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= urfcam_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_map ? urfcam_pkg::RESP_OKAY
                               : urfcam_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= urfcam_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_val;
      s_axi_rresp_o   <= mapped(idx_of(s_axi_araddr_i))
                         ? urfcam_pkg::RESP_OKAY
                         : urfcam_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
    end
  end

  // ==========================================================
  // Line input: three flops, change taken when 2nd and 3rd agree
  logic rx_meta;   // First stage, read only by rx_s2
  logic rx_s2;     // Second stage
  logic rx_s3;     // Third stage
  logic rx_level;  // Filtered line level
  logic rx_prev;   // Previous filtered level

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta  <= 1'b1;
      rx_s2    <= 1'b1;
      rx_s3    <= 1'b1;
      rx_level <= 1'b1;
      rx_prev  <= 1'b1;
    end else begin
      rx_meta <= rx_i;
      rx_s2   <= rx_meta;
      rx_s3   <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_level <= rx_s3;
      end
      rx_prev <= rx_level;
    end
  end

  // ==========================================================
  // Receiver frame sequencer
  urfcam_pkg::urfcam_rx_state_t state;
  logic [15:0] baud_cnt; // Cycles to next sample
  logic [2:0]  bit_cnt;  // Data bit index
  logic [7:0]  shift;    // Data shifter, LSB first
  logic        ninth_q;  // Captured ninth bit
  logic [1:0]  mode;     // Active serial mode
  logic        mode1;    // Eight-bit mode
  logic        tick;     // Mid-bit sample point
  logic        rx_fall;  // Start edge

  assign mode    = {serial_mode_bit0, serial_mode_bit1};
  assign mode1   = (mode == urfcam_pkg::MODE_8BIT);
  assign tick    = (state != urfcam_pkg::RX_IDLE) &&
                   (baud_cnt == 16'h0000);
  assign rx_fall = rx_prev && !rx_level;

  // Own counter and sample point: reception never waits on transmit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= urfcam_pkg::RX_IDLE;
      baud_cnt <= 16'h0000;
      bit_cnt  <= 3'h0;
      shift    <= 8'h00;
      ninth_q  <= 1'b0;
    end else if (!rx_enable) begin
      // Clearing reception enable abandons a frame
      state <= urfcam_pkg::RX_IDLE;
    end else if (state == urfcam_pkg::RX_IDLE) begin
      // async modes receive on own timing
      if (rx_fall && (mode != urfcam_pkg::MODE_SHIFT)) begin
        state    <= urfcam_pkg::RX_START;
        baud_cnt <= baud_div >> 1;
      end
    end else if (baud_cnt != 16'h0000) begin
      baud_cnt <= baud_cnt - 16'h0001;
    end else begin
      baud_cnt <= baud_div;
      case (state)
        urfcam_pkg::RX_START: begin
          // A high start sample is a glitch
          state   <= rx_level ? urfcam_pkg::RX_IDLE
                              : urfcam_pkg::RX_DATA;
          bit_cnt <= 3'h0;
        end
        urfcam_pkg::RX_DATA: begin
          shift   <= {rx_level, shift[7:1]};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            state <= mode1 ? urfcam_pkg::RX_STOP
                           : urfcam_pkg::RX_NINTH;
          end
        end
        urfcam_pkg::RX_NINTH: begin
          ninth_q <= rx_level;
          state   <= urfcam_pkg::RX_STOP;
        end
        default: begin
          state <= urfcam_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Frame decision
  urfcam_match_if mif ();
  logic [7:0] byte_now;  // Data byte as of this sample
  logic       ninth_now; // Ninth bit as of this sample
  logic       ev_last;   // Last data or ninth bit sampled
  logic       ev_stop;   // Stop bit sampled
  logic       mp_active; // Address filter in force
  logic       late;      // Decide at stop bit
  logic       decide;    // Decision point
  logic       accept;    // Frame passes filter
  logic       rx_take;   // Load byte, raise done
  logic       fe_set;    // Framing error event

  assign byte_now  = (state == urfcam_pkg::RX_DATA)
                     ? {rx_level, shift[7:1]} : shift;
  assign ninth_now = (state == urfcam_pkg::RX_NINTH)
                     ? rx_level : ninth_q;
  assign ev_last   = tick &&
                     (((state == urfcam_pkg::RX_DATA) &&
                       (bit_cnt == 3'h7) && mode1) ||
                      (state == urfcam_pkg::RX_NINTH));
  assign ev_stop   = tick && (state == urfcam_pkg::RX_STOP);
  // filter needs the bit and an async mode
  assign mp_active = multiproc_enable &&
                     (mode != urfcam_pkg::MODE_SHIFT);
  // stop-bit decision when checked or in filtered mode 1
  assign late      = frame_check_select || (mode1 && mp_active);
  assign decide    = late ? ev_stop : ev_last;

  assign mif.rx_byte = byte_now;
  assign mif.addr    = node_address;
  assign mif.mask    = node_address_mask;

  urfcam_matcher u_matcher (
    .m (mif.matcher)
  );

  // Filter outcome per mode
  always_comb begin
    accept = 1'b1;
    if (mp_active && mode1) begin
      // match with a valid stop bit
      accept = rx_level && mif.match;
    end else if (mp_active) begin
      accept = ninth_now && mif.match;
    end
  end

  assign rx_take = decide && accept;
  assign fe_set  = ev_stop && frame_check_select && !rx_level;

  // ==========================================================
  // Write strobes per field
  logic wr_sc;  // Serial control write
  logic wr_irq; // Status clear write
  assign wr_sc  = wr_lo(urfcam_pkg::IDX_SERIAL_CTRL);
  assign wr_irq = wr_lo(urfcam_pkg::IDX_IRQ_STATUS);

  // Address, mask, power control, divisor, interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // both address bytes clear on reset
      node_address       <= urfcam_pkg::NODE_ADDR_RST;
      node_address_mask  <= urfcam_pkg::NODE_MASK_RST;
      frame_check_select <= 1'b0;
      baud_div           <= urfcam_pkg::BAUD_DIV_RST;
      irq_mask           <= urfcam_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_lo(urfcam_pkg::IDX_NODE_ADDR)) begin
        node_address <= w_data[7:0];
      end
      if (wr_lo(urfcam_pkg::IDX_NODE_MASK)) begin
        node_address_mask <= w_data[7:0];
      end
      if (wr_lo(urfcam_pkg::IDX_POWER_CTRL)) begin
        frame_check_select <= w_data[urfcam_pkg::PC_FRAME_CHECK];
      end
      if (wr_lo(urfcam_pkg::IDX_IRQ_MASK)) begin
        irq_mask <= w_data[1:0];
      end
      if (wr_fire && (aw_idx == urfcam_pkg::IDX_BAUD_DIV)) begin
        if (w_strb[0]) baud_div[7:0]  <= w_data[7:0];
        if (w_strb[1]) baud_div[15:8] <= w_data[15:8];
      end
    end
  end

  // Serial control bits; hardware events win over writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_mode_bit0   <= 1'b0;
      serial_mode_bit1   <= 1'b0;
      multiproc_enable   <= 1'b0;
      rx_enable          <= 1'b0;
      tx_ninth_bit       <= 1'b0;
      received_ninth_bit <= 1'b0;
      tx_done_flag       <= 1'b0;
      receive_done_flag  <= 1'b0;
      framing_error_flag <= 1'b0;
    end else begin
      if (wr_sc) begin
        // bit 7 routed by the select bit
        if (frame_check_select) begin
          framing_error_flag <= w_data[urfcam_pkg::SC_FE_MODE0];
        end else begin
          serial_mode_bit0 <= w_data[urfcam_pkg::SC_FE_MODE0];
        end
        serial_mode_bit1   <= w_data[urfcam_pkg::SC_MODE1];
        multiproc_enable   <= w_data[urfcam_pkg::SC_MP_EN];
        rx_enable          <= w_data[urfcam_pkg::SC_RX_EN];
        tx_ninth_bit       <= w_data[urfcam_pkg::SC_TX_NINTH];
        received_ninth_bit <= w_data[urfcam_pkg::SC_RX_NINTH];
        tx_done_flag       <= w_data[urfcam_pkg::SC_TX_DONE];
        receive_done_flag  <= w_data[urfcam_pkg::SC_RX_DONE];
      end
      // only set here; valid frames never clear
      if (fe_set) framing_error_flag <= 1'b1;
      if (rx_take) receive_done_flag <= 1'b1;
      if (rx_take && !mode1) received_ninth_bit <= ninth_now;
      // mode 1 unfiltered keeps the stop bit
      if (ev_stop && mode1 && !mp_active) begin
        received_ninth_bit <= rx_level;
      end
    end
  end

  // Received byte buffer, overwritten by each accepted frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data <= 8'h00;
    end else if (rx_take) begin
      rx_data <= byte_now;
    end
  end

  // Sticky events, write one to clear, set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= 2'h0;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~(wr_irq ? w_data[1:0] : 2'h0)) |
                    {fe_set, rx_take};
      irq_o      <= |(irq_status & irq_mask);
    end
  end

  // ==========================================================
  // Read mux; unmapped reads return zero
  always_comb begin
    logic [7:0] ri;
    ri     = idx_of(s_axi_araddr_i);
    rd_val = 32'h0000_0000;
    if (ri == urfcam_pkg::IDX_SERIAL_CTRL) begin
      rd_val[7:0] = {frame_check_select ? framing_error_flag
                                        : serial_mode_bit0,
                     serial_mode_bit1, multiproc_enable, rx_enable,
                     tx_ninth_bit, received_ninth_bit,
                     tx_done_flag, receive_done_flag};
    end else if (ri == urfcam_pkg::IDX_NODE_ADDR) begin
      rd_val[7:0] = node_address;
    end else if (ri == urfcam_pkg::IDX_NODE_MASK) begin
      rd_val[7:0] = node_address_mask;
    end else if (ri == urfcam_pkg::IDX_POWER_CTRL) begin
      rd_val[urfcam_pkg::PC_FRAME_CHECK] = frame_check_select;
    end else if (ri == urfcam_pkg::IDX_RX_DATA) begin
      rd_val[7:0] = rx_data;
    end else if (ri == urfcam_pkg::IDX_BAUD_DIV) begin
      rd_val[15:0] = baud_div;
    end else if (ri == urfcam_pkg::IDX_IRQ_STATUS) begin
      rd_val[1:0] = irq_status;
    end else if (ri == urfcam_pkg::IDX_IRQ_MASK) begin
      rd_val[1:0] = irq_mask;
    end
  end
endmodule // urfcam_top

/* File: verilog/urfcam_pkg.sv */
// Shared constants of the receive-side frame check and address match block.
// Assumes a single 10 MHz core clock and AXI4-Lite register access.
package urfcam_pkg;
  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SERIAL_CTRL = 8'h98;
  localparam logic [7:0] IDX_NODE_ADDR   = 8'ha9;
  localparam logic [7:0] IDX_NODE_MASK   = 8'hb9;
  localparam logic [7:0] IDX_POWER_CTRL  = 8'hc0;
  localparam logic [7:0] IDX_RX_DATA     = 8'hc1;
  localparam logic [7:0] IDX_BAUD_DIV    = 8'hc2;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'hc3;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'hc4;
  // ==========================================================
  // Serial control field positions
  localparam int SC_FE_MODE0 = 7;
  localparam int SC_MODE1    = 6;
  localparam int SC_MP_EN    = 5;
  localparam int SC_RX_EN    = 4;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_DONE  = 1;
  localparam int SC_RX_DONE  = 0;
  // Power control: frame check select position
  localparam int PC_FRAME_CHECK = 6;
  // Interrupt status / mask positions
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_FRAMING = 1;
  // ==========================================================
  // Reset values
  localparam logic [7:0] NODE_ADDR_RST = 8'h00;
  localparam logic [7:0] NODE_MASK_RST = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST  = 2'h0;
  // ==========================================================
  // Timing: default bit time derived from clock and baud rate
  localparam int CLK_HZ       = 10_000_000;
  localparam int BAUD_DEFAULT = 9600;
  localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_DEFAULT - 1);
  // ==========================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Serial modes {mode bit0, mode bit1}
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8BIT  = 2'h1;
  // Receiver states, Gray coded along the frame
  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h3,
    RX_NINTH = 3'h2,
    RX_STOP  = 3'h6
  } urfcam_rx_state_t;
endpackage : urfcam_pkg

/* File: verilog/urfcam_match_if.sv */
// Carrier between the receiver core and its address comparator.
// Purely combinational signals; no clock inside.
interface urfcam_match_if;
  logic [7:0] rx_byte;   // Received address byte
  logic [7:0] addr;      // Node address
  logic [7:0] mask;      // Node address mask
  logic       match;     // Given or broadcast hit
  modport core    (output rx_byte, output addr, output mask,
                   input match);
  modport matcher (input rx_byte, input addr, input mask,
                   output match);
endinterface : urfcam_match_if

/* File: verilog/urfcam_matcher.sv */
// Address comparator: given and broadcast address hit.
// Combinational; the core samples the result on its own clock.
module urfcam_matcher (
  urfcam_match_if.matcher m
);
  // ==========================================================
  // Comparison helpers
  logic [7:0] bcast;     // Broadcast pattern
  logic       given_hit; // Given address hit
  logic       bcast_hit; // Broadcast address hit

  always_comb begin
    bcast = m.addr | m.mask;
    // compare only where mask is one
    given_hit = (((m.rx_byte ^ m.addr) & m.mask) == 8'h00);
    // zero positions of the OR ignored
    bcast_hit = (((m.rx_byte ^ bcast) & bcast) == 8'h00);
    m.match = given_hit | bcast_hit;
  end
endmodule // urfcam_matcher

/* File: tb/urfcam_node_model.sv */
// Far-side serial node that drives async frames onto the receive line.
// Assumes the bench clock and a bit time of BIT_CYC core cycles.
module urfcam_node_model #(
  parameter int BIT_CYC = 8  // Divisor 7 gives eight cycles a bit
) (
  input  wire logic clk_i,
  output logic      line_o
);
  // ========================================
  // Line idles high, as a pulled-up wire would
  initial line_o = 1'b1;
  // Start, eight bits LSB first, optional ninth, then stop
  task automatic send(input logic [7:0] b, input logic u9, n9, st);
    logic [10:0] f;
    int          n;
    f = {st, n9, b, 1'b0};
    n = u9 ? 11 : 10;
    // No ninth bit: stop follows last data bit
    if (!u9) f[9] = st;
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      line_o <= f[k];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    line_o <= 1'b1;
  endtask
endmodule // urfcam_node_model

/* File: tb/urfcam_properties.sv */
// Checker on the top ports: register bus handshakes and interrupt line.
// Assumes one clock and the synchronous active-high reset.
module urfcam_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        irq_o
);
  // ========================================
  // All checks share the core clock and its reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_write_answer: assert property ((s_axi_awvalid_i && s_axi_awready_o
    && s_axi_wvalid_i && s_axi_wready_o) |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("b dropped");
  a_write_blocked: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o) else $error("write not held off");
  a_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
    !s_axi_bvalid_o && s_axi_awready_o) else $error("write not freed");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o) else $error("read response late");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("r dropped");
  a_read_blocked: assert property (s_axi_rvalid_o |->
    !s_axi_arready_o) else $error("read not held off");
  a_r_release: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
    !s_axi_rvalid_o && s_axi_arready_o) else $error("read not freed");
  a_unmapped_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o
    == 2'h2 |-> s_axi_rdata_o == 32'h0) else $error("error data nonzero");
  // Sticky flags: line falls only after a write
  a_irq_sticky: assert property ($fell(irq_o) |->
    $past(s_axi_bvalid_o)) else $error("interrupt fell on its own");
  c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
  c_slverr: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2);
  c_irq: cover property ($rose(irq_o));
endmodule // urfcam_properties

bind urfcam_top urfcam_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .irq_o(irq_o));

/* File: tb/urfcam_bench.sv */
// Bench for the receive block: register tasks plus serial frame scenarios.
// Assumes the node model drives the line and the checker is bound.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module uart_rx_frame_check_addr_match_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ========================================
  // Register indices used here
  localparam logic [7:0] SC = urfcam_pkg::IDX_SERIAL_CTRL;
  localparam logic [7:0] IS = urfcam_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] IM = urfcam_pkg::IDX_IRQ_MASK;
  logic        clk_i, rst_i, awv, wv, br, arv, rr, awr, wr_o, bv, arr, rv;
  logic        rx, irq;
  logic [11:0] aw, ar;
  logic [31:0] wd, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          bad_count, n_checks, cyc;
  // Address cases: byte, stop bit, accepted
  logic [7:0]  vb [5] = '{8'h57, 8'h5a, 8'hff, 8'h57, 8'hfb};
  logic        vs [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic        ve [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  urfcam_top DUT (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(aw),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rr), .rx_i(rx), .irq_o(irq));
  urfcam_node_model node (.clk_i(clk_i), .line_o(rx));
  // ========================================
  // Clock of 100 ns
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Write: address and data together, late answer
  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    aw <= {2'h0, i, 2'h0};
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    do @(posedge clk_i); while (awr !== 1'b1 || wr_o !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge clk_i); while (bv !== 1'b1);
    br <= 1'b1;
    do @(posedge clk_i); while (bv !== 1'b1);
    r = bresp;
    br <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i);
    ar <= {2'h0, i, 2'h0};
    arv <= 1'b1;
    do @(posedge clk_i); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk_i); while (rv !== 1'b1);
    rr <= 1'b1;
    do @(posedge clk_i); while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    rr <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] i, m, e);
    rd(i);
    `CHK($sformatf("reg %h", i), e, d[7:0] & m)
  endtask
  // Frame then margin for filter lag
  task automatic frm(input logic [7:0] b, input logic u9, n9, st);
    node.send(b, u9, n9, st);
    repeat (24) @(posedge clk_i);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    {awv, wv, br, arv, rr, aw, ar, wd} = '0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(8'ha9, 8'hff, 8'h00);
    chk(8'hb9, 8'hff, 8'h00);
    rd(8'h10);
    `CHK("unmapped resp", urfcam_pkg::RESP_SLVERR, r)
    wr(urfcam_pkg::IDX_BAUD_DIV, 32'h7);
    `CHK("write resp", urfcam_pkg::RESP_OKAY, r)
    wr(IM, 32'h3);
    wr(SC, 32'h70);
    frm(8'h3c, 1'b0, 1'b0, 1'b1);
    chk(SC, 8'h01, 8'h01);
    chk(urfcam_pkg::IDX_RX_DATA, 8'hff, 8'h3c);
    wr(8'ha9, 32'h56);
    wr(8'hb9, 32'hfc);
    for (int k = 0; k < 5; k++) begin
      wr(SC, 32'h70);
      frm(vb[k], 1'b0, 1'b0, vs[k]);
      chk(SC, 8'h01, {7'h0, ve[k]});
    end
    // Shift mode ignores the filter and receives nothing
    wr(SC, 32'h30);
    frm(8'h57, 1'b0, 1'b0, 1'b1);
    chk(SC, 8'h01, 8'h00);
    wr(SC, 32'hb0);
    frm(8'h57, 1'b1, 1'b0, 1'b1);
    chk(SC, 8'h01, 8'h00);
    frm(8'h57, 1'b1, 1'b1, 1'b1);
    chk(SC, 8'h85, 8'h85);
    wr(SC, 32'h50);
    frm(8'h3c, 1'b0, 1'b0, 1'b1);
    chk(SC, 8'h04, 8'h04);
    wr(SC, 32'h50);
    frm(8'h3c, 1'b0, 1'b0, 1'b0);
    chk(SC, 8'h84, 8'h00);
    wr(IS, 32'h3);
    wr(urfcam_pkg::IDX_POWER_CTRL, 32'h40);
    frm(8'h3c, 1'b0, 1'b0, 1'b0);
    chk(SC, 8'h81, 8'h81);
    chk(IS, 8'h03, 8'h03);
    wr(SC, 32'hd0);
    frm(8'h3c, 1'b0, 1'b0, 1'b1);
    chk(SC, 8'h80, 8'h80);
    wr(IS, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK("irq raised", 1'b1, irq)
    wr(IM, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK("irq masked", 1'b0, irq)
    wr(IM, 32'h3);
    wr(IS, 32'h2);
    repeat (2) @(posedge clk_i);
    `CHK("irq cleared", 1'b0, irq)
    wr(SC, 32'h50);
    chk(SC, 8'h80, 8'h00);
    summarize();
  end
endmodule // uart_rx_frame_check_addr_match_bench
